/* File: sxa_alu.v */
// subtract-with-borrow and exclusive-or datapath for an 8-bit core
`timescale 1ns/10ps
`include "sxa_alu_map.vh"
module sxa_alu (
   // clock and reset
   input wire clk,
   input wire rstn,
   // instruction from decoder
   input wire opValid,
   input wire [2:0] opSel,
   input wire destSel,
   input wire [7:0] literal,
   // file register read data
   input wire [7:0] fileRdData,
   // file register write back
   output reg fileWrEn,
   output reg [7:0] fileWrData,
   // accumulator and status
   output wire [7:0] accOut,
   output wire carryFlag,
   output wire digitCarryFlag,
   output wire zeroFlag
);

   // =========================================
   // sizes
   localparam DATA_W = 8;
   localparam NIB_W = 4;
   localparam FLAG_W = 3;

   // =========================================
   // state
   reg [7:0] acc_q;
   reg [7:0] acc_d;
   reg [FLAG_W-1:0] flags_q;
   reg [FLAG_W-1:0] flags_d;
   reg fileWrEn_d;
   reg [7:0] fileWrData_d;

   // =========================================
   // decode helpers
   // ops that read their operand from the file register
   function isFileOp;
      input [2:0] code;
      begin
         case (code)
            `SXA_OP_SUB_FILE_WITH_BORROW: begin
               isFileOp = 1'h1;
            end
            `SXA_OP_XOR_ACC_WITH_FILE: begin
               isFileOp = 1'h1;
            end
            default: begin
               isFileOp = 1'h0;
            end
         endcase
      end
   endfunction

   // ops carried out here, all other codes are ignored
   function isKnownOp;
      input [2:0] code;
      begin
         case (code)
            `SXA_OP_SUB_FILE_WITH_BORROW: begin
               isKnownOp = 1'h1;
            end
            `SXA_OP_XOR_LITERAL_TO_ACC: begin
               isKnownOp = 1'h1;
            end
            `SXA_OP_XOR_ACC_WITH_FILE: begin
               isKnownOp = 1'h1;
            end
            default: begin
               isKnownOp = 1'h0;
            end
         endcase
      end
   endfunction

   // destination bit points at the file register
   function destIsFile;
      input dest;
      begin
         destIsFile = (dest == `SXA_DEST_FILE);
      end
   endfunction

   // =========================================
   // instruction decode
   wire opTaken;
   wire opSub;
   wire opXorLit;
   wire writeFile;
   wire writeAcc;
   assign opTaken = opValid & isKnownOp(opSel);
   assign opSub = opTaken & (opSel == `SXA_OP_SUB_FILE_WITH_BORROW);
   assign opXorLit = opTaken & (opSel == `SXA_OP_XOR_LITERAL_TO_ACC);
   // destination bit only steers the file register ops
   assign writeFile = opTaken & isFileOp(opSel)
      & destIsFile(destSel);
   assign writeAcc = opXorLit | (opTaken & isFileOp(opSel)
      & ~destIsFile(destSel));

   // =========================================
   // subtract with borrow as a ripple borrow chain
   wire [DATA_W:0] borrowChain;
   wire [DATA_W-1:0] diffBits;
   wire noBorrow;
   wire noNibBorrow;
   wire diffZero;
   genvar i;
   // a clear carry means one more is owed
   assign borrowChain[0] = ~flags_q[`SXA_FLAG_C];
   generate
      for (i = 0; i < DATA_W; i = i + 1) begin : g_sub
         assign diffBits[i] = fileRdData[i] ^ acc_q[i] ^ borrowChain[i];
         assign borrowChain[i + 1] = (~fileRdData[i] & acc_q[i])
            | (~fileRdData[i] & borrowChain[i])
            | (acc_q[i] & borrowChain[i]);
      end
   endgenerate
   assign noBorrow = ~borrowChain[DATA_W];
   assign noNibBorrow = ~borrowChain[NIB_W];
   assign diffZero = (diffBits == 8'h00);

   // =========================================
   // exclusive or against literal or file operand
   wire [DATA_W-1:0] xorOperand;
   wire [DATA_W-1:0] xorBits;
   assign xorOperand = opXorLit ? literal : fileRdData;
   generate
      for (i = 0; i < DATA_W; i = i + 1) begin : g_xor
         assign xorBits[i] = acc_q[i] ^ xorOperand[i];
      end
   endgenerate

   // =========================================
   // result select
   wire [DATA_W-1:0] opResult;
   assign opResult = opSub ? diffBits : xorBits;

   // =========================================
   // next accumulator
   always @* begin
      acc_d = acc_q;
      if (writeAcc) begin
         acc_d = opResult;
      end
   end

   // =========================================
   // next flags, exclusive or leaves them alone
   always @* begin
      flags_d = flags_q;
      if (opSub) begin
         flags_d[`SXA_FLAG_C] = noBorrow;
         flags_d[`SXA_FLAG_DC] = noNibBorrow;
         flags_d[`SXA_FLAG_Z] = diffZero;
      end
   end

   // =========================================
   // next file write back, a one-cycle strobe
   always @* begin
      fileWrEn_d = 1'h0;
      fileWrData_d = fileWrData;
      if (writeFile) begin
         fileWrEn_d = 1'h1;
         fileWrData_d = opResult;
      end
   end

   // =========================================
   // registers
   // accumulator
   always @(posedge clk) begin
      if (!rstn) begin
         acc_q <= `SXA_ACC_RST;
      end else begin
         acc_q <= acc_d;
      end
   end

   // status flags
   always @(posedge clk) begin
      if (!rstn) begin
         flags_q <= `SXA_FLAGS_RST;
      end else begin
         flags_q <= flags_d;
      end
   end

   // write strobe
   always @(posedge clk) begin
      if (!rstn) begin
         fileWrEn <= 1'h0;
      end else begin
         fileWrEn <= fileWrEn_d;
      end
   end

   // write data, held between writes
   always @(posedge clk) begin
      if (!rstn) begin
         fileWrData <= 8'h00;
      end else begin
         fileWrData <= fileWrData_d;
      end
   end

   // =========================================
   // outputs
   assign accOut = acc_q;
   assign carryFlag = flags_q[`SXA_FLAG_C];
   assign digitCarryFlag = flags_q[`SXA_FLAG_DC];
   assign zeroFlag = flags_q[`SXA_FLAG_Z];

endmodule

/* File: sxa_alu_map.vh */
// constants for the subtract/exclusive-or datapath
`ifndef SXA_ALU_MAP_VH
`define SXA_ALU_MAP_VH
// op select codes (one-hot, except none which is zero)
`define SXA_OP_NONE 3'h0
`define SXA_OP_SUB_FILE_WITH_BORROW 3'h1
`define SXA_OP_XOR_LITERAL_TO_ACC 3'h2
`define SXA_OP_XOR_ACC_WITH_FILE 3'h4
// destination select values
`define SXA_DEST_ACC 1'h0
`define SXA_DEST_FILE 1'h1
// flag vector positions {zero, digit carry, carry}
`define SXA_FLAG_C 0
`define SXA_FLAG_DC 1
`define SXA_FLAG_Z 2
// reset values
`define SXA_ACC_RST 8'h00
`define SXA_FLAGS_RST 3'h0
`endif

/* File: sxa_alu_assertions.sv */
// checker for the subtract and exclusive-or datapath
`timescale 1ns/10ps
module sxa_alu_chk (input wire clk, rstn, opValid, destSel, fileWrEn,
   carryFlag, digitCarryFlag, zeroFlag, input wire [2:0] opSel,
   input wire [7:0] literal, fileRdData, fileWrData, accOut);
default clocking @(posedge clk); endclocking
default disable iff (!rstn);
wire s = opValid && opSel == 3'h1;
wire x = opValid && opSel == 3'h4;
sub_value_a: assert property (s && destSel |=> fileWrData ==
   $past(fileRdData) - $past(accOut) - !$past(carryFlag)) else $error("sub");
sub_zero_a: assert property (s && destSel |=>
   zeroFlag == (fileWrData == 8'h0)) else $error("zero flag");
sub_carry_a: assert property (s |=> carryFlag == ($past(fileRdData) >=
   {1'b0, $past(accOut)} + !$past(carryFlag))) else $error("carry flag");
sub_digit_a: assert property (s |=> digitCarryFlag ==
   ({1'b0, $past(fileRdData[3:0])} >= {1'b0, $past(accOut[3:0])} +
   !$past(carryFlag))) else $error("digit carry");
dest_sel_a: assert property (s || x |=>
   fileWrEn == $past(destSel)) else $error("destination");
lit_xor_a: assert property (opValid && opSel == 3'h2 |=>
   accOut == ($past(accOut) ^ $past(literal))) else $error("xor literal");
file_xor_a: assert property (x && !destSel |=>
   accOut == ($past(accOut) ^ $past(fileRdData))) else $error("xor file");
xor_write_a: assert property (x && destSel |=>
   fileWrData == ($past(accOut) ^ $past(fileRdData))) else $error("xor write");
no_write_a: assert property (!(s || x) |=> !fileWrEn)
   else $error("stray write");
endmodule
bind sxa_alu sxa_alu_chk u_chk (.clk, .rstn, .opValid, .destSel, .fileWrEn,
   .carryFlag, .digitCarryFlag, .zeroFlag, .opSel, .literal, .fileRdData,
   .fileWrData, .accOut);

/* File: sxa_alu_tb.sv */
// self-checking bench for the subtract and exclusive-or datapath
`timescale 1ns/10ps
module sxa_alu_tb;
reg clk = 0, rstn = 0, opValid = 0, destSel = 0;
reg [2:0] opSel = 0;
reg [7:0] literal = 0, fileRdData = 0;
wire fileWrEn, carryFlag, digitCarryFlag, zeroFlag;
wire [7:0] fileWrData, accOut;
integer n_fail = 0, num_checks = 0;
sxa_alu u_sxa_alu (.clk(clk), .rstn(rstn), .opValid(opValid),
   .opSel(opSel), .destSel(destSel), .literal(literal),
   .fileRdData(fileRdData), .fileWrEn(fileWrEn), .fileWrData(fileWrData),
   .accOut(accOut), .carryFlag(carryFlag),
   .digitCarryFlag(digitCarryFlag), .zeroFlag(zeroFlag));
initial forever #20 clk = ~clk;
task chk(input [31:0] nm, input [7:0] s, e);
   begin
      num_checks = num_checks + 1;
      if (s !== e) begin
         n_fail = n_fail + 1;
         $display("[ERR] %0s exp %h got %h", nm, e, s);
      end
   end
endtask
task op(input [2:0] o, input d, input [7:0] k, f);
   begin
      @(posedge clk);
      #1 {opSel, destSel, literal, fileRdData, opValid} = {o, d, k, f, 1'b1};
      @(posedge clk);
      #1 opValid = 0;
   end
endtask
task sb(input [7:0] f, input d, input [7:0] r, input c, dc, z);
   begin
      op(3'h1, d, 8'h00, f);
      chk("res", d ? fileWrData : accOut, r);
      chk("wen", {7'h0, fileWrEn}, {7'h0, d});
      chk("flg", {5'h0, zeroFlag, digitCarryFlag, carryFlag},
         {5'h0, z, dc, c});
   end
endtask
task t_sub;
   begin
      op(3'h2, 1'h0, 8'h01, 8'h00);
      sb(8'h33, 1'h1, 8'h31, 1'h1, 1'h1, 1'h0);
      sb(8'h33, 1'h1, 8'h32, 1'h1, 1'h1, 1'h0);
      sb(8'h00, 1'h1, 8'hFF, 1'h0, 1'h0, 1'h0);
      sb(8'h02, 1'h1, 8'h00, 1'h1, 1'h1, 1'h1);
      // acc 01 to 05 for the borrowing pair
      op(3'h2, 1'h0, 8'h04, 8'h00);
      sb(8'h04, 1'h1, 8'hFF, 1'h0, 1'h0, 1'h0);
      sb(8'h04, 1'h1, 8'hFE, 1'h0, 1'h0, 1'h0);
      // acc back to 01
      op(3'h2, 1'h0, 8'h04, 8'h00);
      sb(8'h10, 1'h0, 8'h0E, 1'h1, 1'h0, 1'h0);
      $display("sub test done");
   end
endtask
task t_xor;
   begin
      op(3'h4, 1'b0, 8'h00, 8'hA2);
      chk("acc", accOut, 8'hAC);
      op(3'h4, 1'b1, 8'h00, 8'h5F);
      chk("wr", fileWrData, 8'hF3);
      chk("acc", accOut, 8'hAC);
      op(3'h2, 1'b0, 8'h5F, 8'h00);
      chk("lit", accOut, 8'hF3);
      $display("xor test done");
   end
endtask
task t_refuse;
   begin
      @(posedge clk);
      #1 {opSel, destSel, fileRdData} = {3'h1, 1'h1, 8'h00};
      @(posedge clk);
      @(posedge clk);
      #1 chk("idl", {7'h0, fileWrEn}, 8'h00);
      op(3'h3, 1'h1, 8'h55, 8'h55);
      chk("unk", {7'h0, fileWrEn}, 8'h00);
      chk("wrd", fileWrData, 8'hF3);
      chk("acc", accOut, 8'hF3);
      chk("flg", {5'h0, zeroFlag, digitCarryFlag, carryFlag},
         8'h01);
      $display("refuse test done");
   end
endtask
task close_out;
   begin
      $display("checks %0d fails %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   end
endtask
initial begin
   repeat (4) @(posedge clk);
   #1 rstn = 1;
   t_sub;
   t_xor;
   t_refuse;
   close_out;
end
endmodule
